// File: rtl/ddrsp_pkg.sv
package ddrsp_pkg;
   // Organisation defaults: 512K bursts of two 36-bit words
   localparam int DDRSP_DATA_W = 36;
   localparam int DDRSP_ADDR_W = 19;
   localparam int DDRSP_DATA_W_NARROW = 18;
   localparam int DDRSP_LANE_W = 9;
   localparam int DDRSP_FIFO_DEPTH = 8;
   localparam int DDRSP_SYNC_STAGES = 2;
   // Read latency in true-clock rises after the command rise
   localparam int DDRSP_LAT_DLL = 2;
   localparam int DDRSP_LAT_BYPASS = 1;
   // Link clock period used by the bench, and the system clock period
   localparam int DDRSP_LINK_PERIOD_NS = 80;
   localparam int DDRSP_CLOCK_PERIOD_NS = 10;
   localparam int DDRSP_LINK_CYCLES = DDRSP_LINK_PERIOD_NS / DDRSP_CLOCK_PERIOD_NS;
   // Burst word select
   localparam logic DDRSP_BEAT_FIRST = 1'b0;
   localparam logic DDRSP_BEAT_SECOND = 1'b1;
   // Reset levels of the pins the block drives
   localparam logic DDRSP_ECHO_TRUE_RST = 1'b0;
   localparam logic DDRSP_ECHO_COMP_RST = 1'b1;
   localparam logic DDRSP_VALID_RST = 1'b0;
   localparam logic DDRSP_OE_RST = 1'b0;
   // Direction select level meaning read
   localparam logic DDRSP_DIR_READ = 1'b1;

   typedef enum logic {
      DDRSP_WR_IDLE,
      DDRSP_WR_WAIT_SECOND
   } ddrsp_wr_state_t;
endpackage

// File: rtl/ddrsp_fifo.sv
`timescale 1ns/10ps
module ddrsp_fifo
   import ddrsp_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = DDRSP_FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depth_check
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wrPtr_reg;
   logic [PTR_W-1:0] rdPtr_reg;
   logic [PTR_W:0] count_reg;
   logic pushFire;
   logic popFire;

   assign inReady = (count_reg != (PTR_W+1)'(DEPTH));
   assign outValid = (count_reg != '0);
   assign outData = store[rdPtr_reg];
   assign pushFire = ce && inValid && inReady;
   assign popFire = ce && outValid && outReady;

   always_ff @(posedge clock) begin
      if (pushFire) begin
         store[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (pushFire) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (popFire) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (pushFire && !popFire) begin
            count_reg <= count_reg + 1'b1;
         end else if (popFire && !pushFire) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// File: rtl/ddrsp_port.sv
`timescale 1ns/10ps
module ddrsp_port
   import ddrsp_pkg::*;
#(
   parameter int DATA_W = DDRSP_DATA_W,
   parameter int ADDR_W = DDRSP_ADDR_W
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic kClkTrue,
   input wire logic kClkComp,
   input wire logic cycle_load_n,
   input wire logic readNotWrite,
   input wire logic [ADDR_W-1:0] addr_bus,
   input wire logic [DATA_W/DDRSP_LANE_W-1:0] lane_write_mask_n,
   input wire logic dllRun_n,
   input wire logic [DATA_W-1:0] shared_io_bus_in,
   output logic [DATA_W-1:0] shared_io_bus_out,
   output logic shared_io_bus_oe,
   output logic echo_strobe_true,
   output logic echo_strobe_comp,
   output logic read_valid_flag,
   output logic writeBufFull
);
   localparam int MASK_W = DATA_W / DDRSP_LANE_W;
   localparam int WORD_A = ADDR_W + 1;
   localparam int ENTRY_W = WORD_A + MASK_W + DATA_W;
   localparam int PIN_W = 5 + ADDR_W + MASK_W + DATA_W;

   if (!((DATA_W == DDRSP_DATA_W && ADDR_W == DDRSP_ADDR_W) ||
         (DATA_W == DDRSP_DATA_W_NARROW && ADDR_W == DDRSP_ADDR_W + 1))) begin : g_org_check
      $error("only the 36-bit x 512K and 18-bit x 1M organisations are served");
   end

   // Two-stage synchronisers; stage one is read by stage two only
   logic [PIN_W-1:0] pinMeta_reg;
   logic [PIN_W-1:0] pinSync_reg;
   logic kTrueOld_reg;
   logic kCompOld_reg;
   logic kRise;
   logic kbRise;
   logic loadN;
   logic dirRead;
   logic bypass;
   logic [ADDR_W-1:0] addrIn;
   logic [MASK_W-1:0] maskIn;
   logic [DATA_W-1:0] dataIn;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
         kTrueOld_reg <= 1'b0;
         kCompOld_reg <= 1'b0;
      end else if (ce) begin
         pinMeta_reg <= {kClkTrue, kClkComp, cycle_load_n, readNotWrite, dllRun_n,
                         addr_bus[ADDR_W-1:1], addr_bus[0], lane_write_mask_n, shared_io_bus_in};
         pinSync_reg <= pinMeta_reg;
         kTrueOld_reg <= pinSync_reg[PIN_W-1];
         kCompOld_reg <= pinSync_reg[PIN_W-2];
      end
   end

   // Pins and clock edges pass the same two stages, so they stay aligned
   assign kRise = ce && pinSync_reg[PIN_W-1] && !kTrueOld_reg;
   assign kbRise = ce && pinSync_reg[PIN_W-2] && !kCompOld_reg;
   assign loadN = pinSync_reg[PIN_W-3];
   assign dirRead = (pinSync_reg[PIN_W-4] == DDRSP_DIR_READ);
   assign bypass = !pinSync_reg[PIN_W-5];
   assign addrIn = pinSync_reg[DATA_W+MASK_W +: ADDR_W];
   assign maskIn = pinSync_reg[DATA_W +: MASK_W];
   assign dataIn = pinSync_reg[DATA_W-1:0];

   logic readCmd;
   logic writeCmd;
   assign readCmd = kRise && !loadN && dirRead;
   assign writeCmd = kRise && !loadN && !dirRead;

   // Late-write path: one word per captured beat enters the buffer
   ddrsp_wr_state_t wrState_reg;
   logic wrQueued_reg;
   logic [ADDR_W-1:0] wrAddrQ_reg;
   logic [ADDR_W-1:0] wrAddr_reg;
   logic pushValid_reg;
   logic [ENTRY_W-1:0] pushEntry_reg;
   logic pushReady;
   logic drainValid;
   logic drainReady;
   logic [ENTRY_W-1:0] drainEntry;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wrState_reg <= DDRSP_WR_IDLE;
         wrQueued_reg <= 1'b0;
         wrAddrQ_reg <= '0;
         wrAddr_reg <= '0;
         pushValid_reg <= 1'b0;
         pushEntry_reg <= '0;
      end else if (ce) begin
         pushValid_reg <= 1'b0;
         if (kRise) begin
            wrQueued_reg <= writeCmd;
            if (writeCmd) begin
               wrAddrQ_reg <= addrIn;
            end
         end
         case (wrState_reg)
            DDRSP_WR_IDLE: begin
               if (kRise && wrQueued_reg) begin
                  // First beat comes one cycle after its command
                  pushValid_reg <= 1'b1;
                  pushEntry_reg <= {wrAddrQ_reg, DDRSP_BEAT_FIRST, maskIn, dataIn};
                  wrAddr_reg <= wrAddrQ_reg;
                  wrState_reg <= DDRSP_WR_WAIT_SECOND;
               end
            end
            DDRSP_WR_WAIT_SECOND: begin
               if (kbRise) begin
                  pushValid_reg <= 1'b1;
                  pushEntry_reg <= {wrAddr_reg, DDRSP_BEAT_SECOND, maskIn, dataIn};
                  wrState_reg <= DDRSP_WR_IDLE;
               end
            end
            default: begin
               wrState_reg <= DDRSP_WR_IDLE;
            end
         endcase
      end
   end

   ddrsp_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(DDRSP_FIFO_DEPTH)
   ) u_write_buf (
      .clock(clock),
      .rst_b(rst_b),
      .ce(ce),
      .inValid(pushValid_reg),
      .inReady(pushReady),
      .inData(pushEntry_reg),
      .outValid(drainValid),
      .outReady(drainReady),
      .outData(drainEntry)
   );

   // Read pipeline, one stage per true-clock rise
   logic [DDRSP_LAT_DLL-1:0] rdPipe_reg;
   logic [ADDR_W-1:0] rdAddrPipe_reg [DDRSP_LAT_DLL];
   logic launchFirst;
   logic launchSecond;
   logic [ADDR_W-1:0] launchAddr;
   logic secondPend_reg;
   logic [ADDR_W-1:0] secondAddr_reg;

   always_comb begin
      if (bypass) begin
         launchFirst = kRise && rdPipe_reg[DDRSP_LAT_BYPASS-1];
         launchAddr = rdAddrPipe_reg[DDRSP_LAT_BYPASS-1];
      end else begin
         launchFirst = kRise && rdPipe_reg[DDRSP_LAT_DLL-1];
         launchAddr = rdAddrPipe_reg[DDRSP_LAT_DLL-1];
      end
   end
   assign launchSecond = kbRise && secondPend_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdPipe_reg <= '0;
         for (int i = 0; i < DDRSP_LAT_DLL; i++) begin
            rdAddrPipe_reg[i] <= '0;
         end
         secondPend_reg <= 1'b0;
         secondAddr_reg <= '0;
      end else if (ce) begin
         if (kRise) begin
            // A bypass launch from stage one clears it so it cannot launch twice
            rdPipe_reg <= {rdPipe_reg[DDRSP_LAT_DLL-2:0] & ~{(DDRSP_LAT_DLL-1){bypass}}, readCmd};
            rdAddrPipe_reg[0] <= addrIn;
            for (int i = 1; i < DDRSP_LAT_DLL; i++) begin
               rdAddrPipe_reg[i] <= rdAddrPipe_reg[i-1];
            end
         end
         if (launchFirst) begin
            secondPend_reg <= 1'b1;
            secondAddr_reg <= launchAddr;
         end else if (launchSecond) begin
            secondPend_reg <= 1'b0;
         end
      end
   end

   // Single-port array: a read beat owns the port, draining waits a cycle
   logic [DATA_W-1:0] mem [2**WORD_A];
   logic [WORD_A-1:0] drainAddr;
   logic [MASK_W-1:0] drainMaskN;
   logic [DATA_W-1:0] drainData;

   assign drainReady = !(launchFirst || launchSecond);
   assign drainAddr = drainEntry[ENTRY_W-1 -: WORD_A];
   assign drainMaskN = drainEntry[DATA_W +: MASK_W];
   assign drainData = drainEntry[DATA_W-1:0];

   // Writes settle a few system cycles after the second beat, well before
   // the earliest read beat that could see them
   always_ff @(posedge clock) begin
      if (ce && drainValid && drainReady) begin
         for (int l = 0; l < MASK_W; l++) begin
            if (!drainMaskN[l]) begin
               mem[drainAddr][l*DDRSP_LANE_W +: DDRSP_LANE_W] <= drainData[l*DDRSP_LANE_W +: DDRSP_LANE_W];
            end
         end
      end
   end

   // Output registers, echo strobes and valid flag
   logic [DATA_W-1:0] busOut_reg;
   logic busOe_reg;
   logic echoTrue_reg;
   logic echoComp_reg;
   logic valid_reg;
   logic bufFull_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busOut_reg <= '0;
         busOe_reg <= DDRSP_OE_RST;
         valid_reg <= DDRSP_VALID_RST;
      end else if (ce) begin
         if (launchFirst) begin
            busOut_reg <= mem[{launchAddr, DDRSP_BEAT_FIRST}];
            busOe_reg <= 1'b1;
            valid_reg <= 1'b1;
         end else if (launchSecond) begin
            busOut_reg <= mem[{secondAddr_reg, DDRSP_BEAT_SECOND}];
         end else if (kRise) begin
            busOe_reg <= 1'b0;
            valid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         echoTrue_reg <= DDRSP_ECHO_TRUE_RST;
         echoComp_reg <= DDRSP_ECHO_COMP_RST;
      end else if (ce) begin
         if (kRise) begin
            echoTrue_reg <= 1'b1;
            echoComp_reg <= 1'b0;
         end else if (kbRise) begin
            echoTrue_reg <= 1'b0;
            echoComp_reg <= 1'b1;
         end
      end
   end

   // A write beat offered to a full buffer is lost; software watches this
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bufFull_reg <= 1'b0;
      end else if (ce) begin
         bufFull_reg <= !pushReady;
      end
   end

   assign shared_io_bus_out = busOut_reg;
   assign shared_io_bus_oe = busOe_reg;
   assign echo_strobe_true = echoTrue_reg;
   assign echo_strobe_comp = echoComp_reg;
   assign read_valid_flag = valid_reg;
   assign writeBufFull = bufFull_reg;
endmodule

// File: dv/ddrsp_host_model.sv
`timescale 1ns/10ps
module ddrsp_host_model
   import ddrsp_pkg::*;
(
   input wire logic clock,
   input wire logic [DDRSP_DATA_W-1:0] shared_io_bus_out,
   input wire logic shared_io_bus_oe,
   output logic kClkTrue,
   output logic kClkComp,
   output logic cycle_load_n,
   output logic readNotWrite,
   output logic [DDRSP_ADDR_W-1:0] addr_bus,
   output logic [3:0] lane_write_mask_n,
   output logic [DDRSP_DATA_W-1:0] shared_io_bus_in
);
   logic [DDRSP_DATA_W-1:0] hostData;
   logic [DDRSP_DATA_W-1:0] lastBus;
   logic hostDrive;
   // Memory clocks run free; the offset keeps link edges off system edges
   initial begin
      kClkTrue = 1'b0;
      kClkComp = 1'b1;
      cycle_load_n = 1'b1;
      readNotWrite = 1'b0;
      addr_bus = '0;
      lane_write_mask_n = 4'hf;
      hostData = '0;
      hostDrive = 1'b0;
      #3.3;
      forever begin
         #(DDRSP_LINK_PERIOD_NS / 2);
         kClkTrue = ~kClkTrue;
         kClkComp = ~kClkTrue;
      end
   end
   // A floating bus shows the inverse of its last level
   always @(posedge clock) lastBus <= shared_io_bus_in;
   assign shared_io_bus_in = shared_io_bus_oe ? shared_io_bus_out : (hostDrive ? hostData : ~lastBus);
   // Pins move midway between link edges for two cycles of setup and hold
   task automatic slot(output logic toTrue);
      @(posedge kClkTrue or posedge kClkComp);
      repeat (2) @(negedge clock);
      toTrue = !kClkTrue;
   endtask
   task automatic kCycle(input logic ldn, input logic rw, input logic [DDRSP_ADDR_W-1:0] a,
         input logic [DDRSP_DATA_W-1:0] d0, input logic [3:0] m0,
         input logic [DDRSP_DATA_W-1:0] d1, input logic [3:0] m1, input logic drv);
      logic toTrue;
      toTrue = 1'b0;
      while (!toTrue) slot(toTrue);
      cycle_load_n = ldn;
      readNotWrite = rw;
      addr_bus = a;
      hostData = d0;
      lane_write_mask_n = m0;
      hostDrive = drv;
      slot(toTrue);
      cycle_load_n = 1'b1;
      hostData = d1;
      lane_write_mask_n = m1;
   endtask
endmodule

// File: dv/ddrsp_port_assertions.sv
`timescale 1ns/10ps
module ddrsp_port_checker
   import ddrsp_pkg::*;
#(
   parameter int DATA_W = DDRSP_DATA_W
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [DATA_W-1:0] shared_io_bus_out,
   input wire logic shared_io_bus_oe,
   input wire logic echo_strobe_true,
   input wire logic echo_strobe_comp,
   input wire logic read_valid_flag
);
   logic echoPrev_reg;
   logic [3:0] quietCnt_reg;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // Bound suits an 80 ns link clock held high by clock enable
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         echoPrev_reg <= DDRSP_ECHO_TRUE_RST;
         quietCnt_reg <= 4'h0;
      end else begin
         echoPrev_reg <= echo_strobe_true;
         if (echo_strobe_true != echoPrev_reg) quietCnt_reg <= 4'h0;
         else if (quietCnt_reg != 4'hf) quietCnt_reg <= quietCnt_reg + 4'h1;
      end
   end
   a_echo_pair: assert property (echo_strobe_comp == !echo_strobe_true)
      else $error("Echo strobes not complementary");
   a_echo_free_run: assert property (quietCnt_reg < 4'hc)
      else $error("Echo strobe stopped");
   a_valid_with_oe: assert property (read_valid_flag == shared_io_bus_oe)
      else $error("Valid and drive disagree");
   a_launch_on_true: assert property ($rose(shared_io_bus_oe) |-> $rose(echo_strobe_true))
      else $error("Burst not launched on true edge");
   a_release_on_true: assert property ($fell(shared_io_bus_oe) |-> $rose(echo_strobe_true))
      else $error("Bus released off a true edge");
   a_second_beat: assert property ($rose(read_valid_flag) |-> ##[3:5] ($fell(echo_strobe_true) && read_valid_flag))
      else $error("Second beat misplaced");
   a_burst_of_two: assert property ($rose(read_valid_flag) |-> read_valid_flag [*7])
      else $error("Read burst too short");
   a_beat_holds: assert property (shared_io_bus_oe && $stable(echo_strobe_true) |-> $stable(shared_io_bus_out))
      else $error("Read data moved within a beat");
   c_read: cover property ($rose(read_valid_flag));
   c_back_to_back: cover property (read_valid_flag [*8] ##1 read_valid_flag);
   c_release: cover property ($fell(shared_io_bus_oe));
endmodule
bind ddrsp_port ddrsp_port_checker #(.DATA_W(DATA_W)) u_chk (.clock(clock), .rst_b(rst_b),
   .shared_io_bus_out(shared_io_bus_out), .shared_io_bus_oe(shared_io_bus_oe), .echo_strobe_true(echo_strobe_true),
   .echo_strobe_comp(echo_strobe_comp), .read_valid_flag(read_valid_flag));

// File: dv/ddrsp_port_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module ddrsp_port_tb_top
   import ddrsp_pkg::*;
();
   localparam logic [35:0] W0 = 36'h123456789;
   localparam logic [35:0] W1 = 36'hfedcba987;
   localparam logic [35:0] N0 = 36'h111111111;
   localparam logic [35:0] N1 = 36'h222222222;
   localparam logic [18:0] A = 19'h00005;
   localparam logic [18:0] B = 19'h7ffff;
   logic clock, rst_b, dllRun_n, kClkTrue, kClkComp, cycle_load_n, readNotWrite, shared_io_bus_oe;
   logic echo_strobe_true, echo_strobe_comp, read_valid_flag, writeBufFull;
   logic [18:0] addr_bus;
   logic [3:0] lane_write_mask_n;
   logic [35:0] shared_io_bus_in, shared_io_bus_out;
   logic [35:0] rdQ[$];
   int failures, tests_run, cycles, kRises, validK;
   ddrsp_port u_dut (.clock, .rst_b, .ce(1'b1), .kClkTrue, .kClkComp, .cycle_load_n, .readNotWrite, .addr_bus,
      .lane_write_mask_n, .dllRun_n, .shared_io_bus_in, .shared_io_bus_out, .shared_io_bus_oe, .echo_strobe_true,
      .echo_strobe_comp, .read_valid_flag, .writeBufFull);
   ddrsp_host_model u_host (.clock, .shared_io_bus_out, .shared_io_bus_oe, .kClkTrue, .kClkComp, .cycle_load_n,
      .readNotWrite, .addr_bus, .lane_write_mask_n, .shared_io_bus_in);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge kClkTrue) kRises++;
   always @(posedge read_valid_flag) validK = kRises;
   always @(echo_strobe_true) begin
      #1;
      if (read_valid_flag === 1'b1) rdQ.push_back(shared_io_bus_out);
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (failures == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) u_host.kCycle(1'b1, 1'b0, '0, '0, 4'hf, '0, 4'hf, 1'b0);
   endtask
   task automatic wr(input logic [18:0] a, input logic [35:0] d0, input logic [35:0] d1);
      u_host.kCycle(1'b0, 1'b0, a, '0, 4'hf, '0, 4'hf, 1'b0);
      u_host.kCycle(1'b1, 1'b0, '0, d0, 4'h0, d1, 4'h0, 1'b1);
   endtask
   // The read may share its rise with the previous write's data
   task automatic rd(input logic [18:0] a, input logic [35:0] e0, input logic [35:0] e1, input int lat,
         input logic [35:0] d0 = '0, input logic [3:0] m0 = 4'hf, input logic [35:0] d1 = '0,
         input logic [3:0] m1 = 4'hf);
      int cmdK;
      rdQ.delete();
      u_host.kCycle(1'b0, 1'b1, a, d0, m0, d1, m1, (m0 & m1) != 4'hf);
      cmdK = kRises;
      idle(4);
      `CHK(validK - cmdK, lat)
      `CHK(rdQ.size(), 2)
      `CHK(rdQ[0], e0)
      `CHK(rdQ[1], e1)
      `CHK(writeBufFull, 1'b0)
   endtask
   task automatic t_basic();
      wr(A, W0, W1);
      rd(A, W0, W1, DDRSP_LAT_DLL);
   endtask
   task automatic t_masks();
      wr(B, W1, W0);
      u_host.kCycle(1'b0, 1'b0, B, '0, 4'hf, '0, 4'hf, 1'b0);
      rd(B, {N0[35:9], W1[8:0]}, {W0[35:27], N1[26:0]}, DDRSP_LAT_DLL, N0, 4'h1, N1, 4'h8);
   endtask
   task automatic t_b2b();
      rdQ.delete();
      u_host.kCycle(1'b0, 1'b1, A, '0, 4'hf, '0, 4'hf, 1'b0);
      u_host.kCycle(1'b0, 1'b1, B, '0, 4'hf, '0, 4'hf, 1'b0);
      idle(4);
      `CHK(rdQ.size(), 4)
      `CHK(rdQ[0], W0)
      `CHK(rdQ[3], {W0[35:27], N1[26:0]})
   endtask
   task automatic t_desel();
      u_host.kCycle(1'b1, 1'b0, A, '0, 4'h0, '0, 4'h0, 1'b0);
      u_host.kCycle(1'b1, 1'b0, '0, N0, 4'h0, N1, 4'h0, 1'b1);
      rd(A, W0, W1, DDRSP_LAT_DLL);
   endtask
   // Mid-run reset: pins return to their reset levels, the array keeps its data
   task automatic t_reset();
      idle(1);
      rst_b = 1'b0;
      repeat (2) @(negedge clock);
      `CHK({shared_io_bus_oe, read_valid_flag, echo_strobe_true, echo_strobe_comp, writeBufFull}, {DDRSP_OE_RST, DDRSP_VALID_RST, DDRSP_ECHO_TRUE_RST, DDRSP_ECHO_COMP_RST, 1'b0})
      rst_b = 1'b1;
      rd(A, W0, W1, DDRSP_LAT_DLL);
   endtask
   task automatic t_bypass();
      dllRun_n = 1'b0;
      idle(2);
      rd(A, W0, W1, DDRSP_LAT_BYPASS);
      dllRun_n = 1'b1;
      idle(2);
   endtask
   initial begin
      rst_b = 1'b0;
      dllRun_n = 1'b1;
      repeat (16) @(posedge clock);
      @(negedge clock);
      rst_b = 1'b1;
      t_basic();
      t_masks();
      t_b2b();
      t_desel();
      t_reset();
      t_bypass();
      tally_and_finish();
   end
endmodule
